// ### bjsm_pkg.sv
// Package for the bit-test call, logical shift, address update and MAC slice.
// Assumes a single 25 MHz clock shared with the instruction sequencer.
`default_nettype none

package bjsm_pkg;

	// ************************************************************
	// Widths and timing
	// ************************************************************
	localparam int unsigned CLK_HZ      = 25_000_000;
	localparam int          DW          = 24;
	localparam int          AW          = 56;
	localparam int          RW          = 16;
	localparam logic [3:0]  CYC_CALL    = 4'h6;
	localparam logic [3:0]  CYC_SHIFT   = 4'h2;
	localparam logic [3:0]  CYC_LUA     = 4'h4;
	localparam logic [3:0]  CYC_MAC     = 4'h2;
	localparam logic [15:0] CALL_WORDS  = 16'h0002;
	localparam logic [15:0] ONE_WORD    = 16'h0001;
	localparam logic [4:0]  BIT_MAX     = 5'h17;

	// ************************************************************
	// Opcode field positions
	// ************************************************************
	localparam int F_PP_LSB  = 8;
	localparam int F_SRC_LSB = 8;
	localparam int F_EA_LSB  = 8;
	localparam int F_SN_LSB  = 8;
	localparam int F_SPACE   = 6;
	localparam int F_BIT_LSB = 0;
	localparam int F_QQQ_LSB = 4;
	localparam int F_ACC_D   = 3;
	localparam int F_NEG_K   = 2;
	localparam int F_DST_LSB = 0;
	localparam int F_DST_N   = 3;

	// ************************************************************
	// Source register field groups
	// ************************************************************
	localparam logic [3:0] SRC_GRP_ALU = 4'h1;
	localparam logic [2:0] SRC_GRP_ACC = 3'h1;
	localparam logic [2:0] SRC_GRP_ADR = 3'h2;
	localparam logic [2:0] SRC_GRP_OFS = 3'h3;
	localparam logic [2:0] SRC_GRP_MOD = 3'h4;
	localparam logic [2:0] SRC_GRP_PCU = 3'h7;
	localparam logic [5:0] SRC_ACC_A   = 6'h0e;
	localparam logic [5:0] SRC_ACC_B   = 6'h0f;

	// Operand pairs that step the double-precision sequence
	localparam logic [2:0] QQ_MPY_DP   = 3'h5;
	localparam logic [2:0] QQ_MAC_DP0  = 3'h6;
	localparam logic [2:0] QQ_MAC_DP1  = 3'h4;
	localparam logic [2:0] QQ_MAC_DP2  = 3'h7;

	// ************************************************************
	// Status word layout
	// ************************************************************
	localparam int CC_C  = 0;
	localparam int CC_V  = 1;
	localparam int CC_Z  = 2;
	localparam int CC_N  = 3;
	localparam int CC_U  = 4;
	localparam int CC_E  = 5;
	localparam int CC_L  = 6;
	localparam int CC_S  = 7;
	localparam int SR_S0 = 10;
	localparam int SR_S1 = 11;
	localparam int SR_DM = 14;

	// ************************************************************
	// APB register map
	// ************************************************************
	localparam logic [11:0] ADDR_CTRL   = 12'h000;
	localparam logic [11:0] ADDR_STATUS = 12'h004;
	localparam logic [11:0] ADDR_COUNT  = 12'h008;
	localparam int          CTRL_EN     = 0;
	localparam int          CTRL_DP     = 1;

	typedef enum logic [2:0] {
		OP_CALL_IO  = 3'h0,
		OP_CALL_REG = 3'h1,
		OP_LSL      = 3'h2,
		OP_LSR      = 3'h3,
		OP_LUA      = 3'h4,
		OP_MAC      = 3'h5,
		OP_MAC_IMM  = 3'h6,
		OP_MPY      = 3'h7
	} bjsm_op_t;

	typedef enum logic [0:0] {
		ST_IDLE = 1'h0,
		ST_BUSY = 1'h1
	} bjsm_st_t;

	typedef struct packed {
		bjsm_op_t        op;
		logic [DW-1:0]   word;
		logic [DW-1:0]   ext;
		logic [3:0]      extra;
		logic            move_lim;
		logic [DW-1:0]   src_mem;
		logic [DW-1:0]   src_reg;
		logic [AW-1:0]   acc_a;
		logic [AW-1:0]   acc_b;
		logic [RW-1:0]   pc;
		logic [RW-1:0]   sr;
		logic [RW-1:0]   rn;
		logic [RW-1:0]   nn;
	} bjsm_req_t;

	typedef struct packed {
		logic            acc_we;
		logic            acc_sel;
		logic [AW-1:0]   acc_val;
		logic [RW-1:0]   sr_val;
		logic [RW-1:0]   pc_next;
		logic            push;
		logic [RW-1:0]   push_pc;
		logic [RW-1:0]   push_sr;
		logic            agu_we;
		logic [3:0]      agu_dst;
		logic [RW-1:0]   agu_val;
		logic [5:0]      io_addr;
		logic            io_space;
		logic            dp_step;
		logic            nop;
	} bjsm_res_t;

endpackage

`default_nettype wire

// ### bjsm_exec.sv
// Execution slice: bit-test call, logical shifts, address update, MAC/MULTIPLY_OP.
// Assumes the sequencer supplies fetched operands on the pclk domain.
//
// Notes on behaviour
// - I/O form decodes address, bit, space
// - Call target from second word, two words
// - Call takes six cycles plus extras
// - Register form decodes six-bit source groups
// - Accumulator source scaled, limited, then tested
// - Tested accumulator itself stays unchanged
// - Bit set: push return, status; jump
// - Bit clear: step past call, ignore target
// - Shift left middle word, carry old top
// - Shift left flags: N, Z, V cleared, L
// - Shift right middle word, carry old bottom
// - Shift right flags: N, V cleared, C, Z
// - Shifts take two cycles plus move extras
// - Updated address to destination, sources kept
// - Written address usable two instructions later
// - Destination field: address or offset registers
// - Address update takes four cycles
// - Address update leaves flags alone
// - Signed multiply, add or subtract product
// - Immediate form scales by power of two
// - Double precision: listed pairs do steps
// - Double precision: other ALU ops idle
//
// Implementation choices: register access over APB and the register offsets.
`timescale 1ns/1ps
`default_nettype none

module bjsm_exec
	import bjsm_pkg::*;
(
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Sequencer request
	input  wire logic        req_valid,
	output logic             req_ready,
	input  wire bjsm_req_t   req,
	// Results
	output logic             done,
	output bjsm_res_t        res
);

	// ************************************************************
	// State
	// ************************************************************
	typedef struct packed {
		bjsm_st_t    st;
		logic [4:0]  cnt;
		logic        done;
		bjsm_res_t   res;
		logic        ctrl_en;
		logic        ctrl_dp;
		logic [31:0] ops;
		logic [31:0] rdata;
	} bjsm_state_t;

	bjsm_state_t s_q;
	bjsm_state_t s_d;

	bjsm_res_t          r;
	logic               take;
	logic               dp_mode;
	logic               dp_list;
	logic [AW-1:0]      sel_acc;
	logic [5:0]         src_fld;
	logic [4:0]         bitn;
	logic [DW-1:0]      scl;
	logic               ext_use;
	logic [DW-1:0]      tst_val;
	logic               bit_set;
	logic signed [47:0] prod;
	logic signed [AW-1:0] addend;
	logic [AW:0]        sum;
	logic [AW-1:0]      mac_r;
	logic [3:0]         base;
	logic               addr_ok;

	assign req_ready = (s_q.st == ST_IDLE) && s_q.ctrl_en;
	assign take      = req_valid && req_ready;
	assign dp_mode   = req.sr[SR_DM] || s_q.ctrl_dp;
	assign addr_ok   = (paddr == ADDR_CTRL) || (paddr == ADDR_STATUS) || (paddr == ADDR_COUNT);
	// Zero wait states: read data is captured in the setup phase
	assign pready    = 1'b1;
	assign pslverr   = psel && penable && !addr_ok;
	assign prdata    = s_q.rdata;
	assign done      = s_q.done;
	assign res       = s_q.res;

	// ************************************************************
	// Next state
	// ************************************************************
	always_comb begin
		s_d     = s_q;
		s_d.done = 1'b0;
		r       = '0;
		r.sr_val  = req.sr;
		r.pc_next = req.pc + ONE_WORD;
		sel_acc = req.word[F_ACC_D] ? req.acc_b : req.acc_a;
		src_fld = req.word[F_SRC_LSB +: 6];
		bitn    = req.word[F_BIT_LSB +: 5];
		scl     = '0;
		ext_use = 1'b0;
		tst_val = req.src_mem;
		bit_set = 1'b0;
		prod    = $signed(req.src_mem) * $signed(req.src_reg);
		addend  = {{7{prod[47]}}, prod, 1'b0};
		sum     = '0;
		mac_r   = '0;
		base    = CYC_MAC;
		dp_list = 1'b0;

		// Bit-test call operand
		if (req.op == OP_CALL_IO) begin
			r.io_addr  = req.word[F_PP_LSB +: 6];
			r.io_space = req.word[F_SPACE];
		end else if (req.op == OP_CALL_REG) begin
			if (src_fld == SRC_ACC_A || src_fld == SRC_ACC_B) begin
				sel_acc = src_fld[0] ? req.acc_b : req.acc_a;
				case ({req.sr[SR_S1], req.sr[SR_S0]})
					2'b01: begin
						scl     = sel_acc[48:25];
						ext_use = ~(&sel_acc[55:48] | ~|sel_acc[55:48]);
					end
					2'b10: begin
						scl     = sel_acc[46:23];
						ext_use = ~(&sel_acc[55:46] | ~|sel_acc[55:46]);
					end
					default: begin
						scl     = sel_acc[47:24];
						ext_use = ~(&sel_acc[55:47] | ~|sel_acc[55:47]);
					end
				endcase
				// Only a scratch copy is limited; the stored value is never written
				tst_val = ext_use ? {sel_acc[55], {(DW-1){~sel_acc[55]}}} : scl;
				r.sr_val[CC_S] = req.sr[CC_S] | (scl[DW-1] ^ scl[DW-2]);
				r.sr_val[CC_L] = req.sr[CC_L] | ext_use;
			end else if (src_fld[5:2] == SRC_GRP_ALU || src_fld[5:3] == SRC_GRP_ACC ||
				src_fld[5:3] == SRC_GRP_ADR || src_fld[5:3] == SRC_GRP_OFS ||
				src_fld[5:3] == SRC_GRP_MOD || src_fld[5:3] == SRC_GRP_PCU) begin
				tst_val = req.src_reg;
			end else begin
				tst_val = '0;
			end
		end
		bit_set = (bitn <= BIT_MAX) && tst_val[bitn];

		// Operation results
		case (req.op)
			OP_CALL_IO, OP_CALL_REG: begin
				base = CYC_CALL;
				if (bit_set) begin
					r.push    = 1'b1;
					r.push_pc = req.pc + CALL_WORDS;
					r.push_sr = req.sr;
					r.pc_next = req.ext[RW-1:0];
				end else begin
					r.pc_next = req.pc + CALL_WORDS;
				end
			end
			OP_LSL: begin
				base = CYC_SHIFT;
				if (dp_mode) begin
					r.nop = 1'b1;
				end else begin
					r.acc_we  = 1'b1;
					r.acc_sel = req.word[F_ACC_D];
					r.acc_val = {sel_acc[55:48], sel_acc[46:24], 1'b0, sel_acc[23:0]};
					r.sr_val[CC_C] = sel_acc[47];
					r.sr_val[CC_N] = sel_acc[46];
					r.sr_val[CC_Z] = ~|sel_acc[46:24];
					r.sr_val[CC_V] = 1'b0;
					r.sr_val[CC_L] = req.sr[CC_L] | req.move_lim;
				end
			end
			OP_LSR: begin
				base = CYC_SHIFT;
				if (dp_mode) begin
					r.nop = 1'b1;
				end else begin
					r.acc_we  = 1'b1;
					r.acc_sel = req.word[F_ACC_D];
					r.acc_val = {sel_acc[55:48], 1'b0, sel_acc[47:25], sel_acc[23:0]};
					r.sr_val[CC_C] = sel_acc[24];
					r.sr_val[CC_N] = 1'b0;
					r.sr_val[CC_Z] = ~|sel_acc[47:25];
					r.sr_val[CC_V] = 1'b0;
					r.sr_val[CC_L] = req.sr[CC_L] | req.move_lim;
				end
			end
			OP_LUA: begin
				// Writes only the destination; the sequencer must not read it back
				// before the second following instruction
				base      = CYC_LUA;
				r.agu_we  = 1'b1;
				r.agu_dst = req.word[F_DST_LSB +: 4];
				case (req.word[F_EA_LSB + 3 +: 2])
					2'b00:   r.agu_val = req.rn - req.nn;
					2'b01:   r.agu_val = req.rn + req.nn;
					2'b10:   r.agu_val = req.rn - ONE_WORD;
					default: r.agu_val = req.rn + ONE_WORD;
				endcase
			end
			default: begin
				if (req.op == OP_MAC_IMM) begin
					addend = {{(AW-2*DW){req.src_mem[DW-1]}}, req.src_mem, 24'h000000};
					addend = addend >>> req.word[F_SN_LSB +: 5];
				end
				dp_list = (req.op == OP_MPY) ? (req.word[F_QQQ_LSB +: 3] == QQ_MPY_DP) :
					(req.op == OP_MAC) && (req.word[F_QQQ_LSB +: 3] == QQ_MAC_DP0 ||
					req.word[F_QQQ_LSB +: 3] == QQ_MAC_DP1 ||
					req.word[F_QQQ_LSB +: 3] == QQ_MAC_DP2);
				if (req.word[F_NEG_K]) begin
					addend = -addend;
				end
				sum   = ((req.op == OP_MPY) ? {(AW+1){1'b0}} : {sel_acc[55], sel_acc})
					+ {addend[55], addend};
				mac_r = sum[AW-1:0];
				if (dp_mode && !dp_list) begin
					r.nop = 1'b1;
				end else begin
					r.dp_step = dp_mode;
					r.acc_we  = 1'b1;
					r.acc_sel = req.word[F_ACC_D];
					r.acc_val = mac_r;
					r.sr_val[CC_N] = mac_r[55];
					r.sr_val[CC_Z] = ~|mac_r;
					r.sr_val[CC_V] = sum[AW] ^ sum[AW-1];
					r.sr_val[CC_L] = req.sr[CC_L] | (sum[AW] ^ sum[AW-1]) | req.move_lim;
					r.sr_val[CC_E] = ~(&mac_r[55:47] | ~|mac_r[55:47]);
					r.sr_val[CC_U] = ~(mac_r[47] ^ mac_r[46]);
				end
			end
		endcase

		// Sequencing
		case (s_q.st)
			ST_IDLE: begin
				if (take) begin
					s_d.st  = ST_BUSY;
					s_d.res = r;
					// Address update and immediate MAC have no extension word
					// Taking edge and done edge each use one cycle of the count
					if (req.op == OP_LUA || req.op == OP_MAC_IMM) begin
						s_d.cnt = 5'(base) - 5'h02;
					end else begin
						s_d.cnt = 5'(base) + 5'(req.extra) - 5'h02;
					end
				end
			end
			ST_BUSY: begin
				if (s_q.cnt == 5'h00) begin
					s_d.done = 1'b1;
					s_d.st   = ST_IDLE;
					s_d.ops  = s_q.ops + 32'h00000001;
				end else begin
					s_d.cnt = s_q.cnt - 5'h01;
				end
			end
			default: s_d.st = ST_IDLE;
		endcase

		// APB registers
		if (psel && !penable && !pwrite) begin
			case (paddr)
				ADDR_CTRL:   s_d.rdata = {30'h0, s_q.ctrl_dp, s_q.ctrl_en};
				ADDR_STATUS: s_d.rdata = {16'h0, s_q.res.sr_val[7:0], 7'h0, s_q.st == ST_BUSY};
				ADDR_COUNT:  s_d.rdata = s_q.ops;
				default:     s_d.rdata = 32'h0;
			endcase
		end
		if (psel && penable && pwrite && paddr == ADDR_CTRL && pstrb[0]) begin
			s_d.ctrl_en = pwdata[CTRL_EN];
			s_d.ctrl_dp = pwdata[CTRL_DP];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q         <= '0;
			s_q.st      <= ST_IDLE;
			s_q.ctrl_en <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	// ************************************************************
	// Checks
	// ************************************************************
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	io_decode_a: assert property (
		take && req.op == OP_CALL_IO |-> ##1 res.io_addr == $past(req.word[F_PP_LSB +: 6])
			&& res.io_space == $past(req.word[F_SPACE]))
		else $error("I/O short address or space not decoded");

	call_flow_a: assert property (
		take && (req.op == OP_CALL_IO || req.op == OP_CALL_REG) |-> ##1
			(res.push ? res.pc_next == $past(req.ext[RW-1:0]) && res.push_pc == $past(req.pc) + CALL_WORDS
				: res.pc_next == $past(req.pc) + CALL_WORDS))
		else $error("Call target or return address wrong");

	call_time_a: assert property (
		take && req.op == OP_CALL_IO && req.extra == 4'h0 |-> ##1 !done[*5] ##1 done)
		else $error("Call did not finish in six cycles");

	acc_keep_a: assert property (
		take && req.op == OP_CALL_REG |-> ##1 !res.acc_we)
		else $error("Bit test wrote an accumulator");

	lsl_shift_a: assert property (
		take && req.op == OP_LSL && !dp_mode |-> ##1 res.acc_val[47:24] == {$past(sel_acc[46:24]), 1'b0}
			&& res.acc_val[23:0] == $past(sel_acc[23:0]) && res.sr_val[CC_C] == $past(sel_acc[47]))
		else $error("Left shift result wrong");

	lsl_flags_a: assert property (
		take && req.op == OP_LSL && !dp_mode |-> ##1 !res.sr_val[CC_V]
			&& res.sr_val[CC_N] == res.acc_val[47] && res.sr_val[CC_Z] == (res.acc_val[47:24] == 24'h0))
		else $error("Left shift flags wrong");

	lsr_shift_a: assert property (
		take && req.op == OP_LSR && !dp_mode |-> ##1 res.acc_val[47:24] == {1'b0, $past(sel_acc[47:25])}
			&& res.sr_val[CC_C] == $past(sel_acc[24]) && !res.sr_val[CC_N] && !res.sr_val[CC_V])
		else $error("Right shift result or flags wrong");

	shift_time_a: assert property (
		take && (req.op == OP_LSL || req.op == OP_LSR) && req.extra == 4'h0 |-> ##1 !done ##1 done)
		else $error("Shift did not finish in two cycles");

	lua_regs_a: assert property (
		take && req.op == OP_LUA |-> ##1 res.agu_we && !res.acc_we
			&& res.agu_dst == $past(req.word[3:0]) && res.sr_val == $past(req.sr))
		else $error("Address update wrote wrong place or flags");

	lua_time_a: assert property (
		take && req.op == OP_LUA |-> ##1 !done[*3] ##1 done)
		else $error("Address update did not take four cycles");

	dp_nop_a: assert property (
		take && dp_mode && (req.op == OP_LSL || req.op == OP_LSR || req.op == OP_MAC_IMM)
			|-> ##1 res.nop && !res.acc_we && !res.dp_step)
		else $error("ALU op ran in double precision mode");

	mac_add_a: assert property (
		take && req.op == OP_MAC && !dp_mode && !req.word[F_NEG_K] |-> ##1
			res.acc_val == $past(sel_acc) + {{7{$past(prod[47])}}, $past(prod), 1'b0})
		else $error("Multiply-accumulate sum wrong");

endmodule

`default_nettype wire

// ### bjsm_seq_model.sv
// Sequencer model: offers one request at a time and holds it until taken or until 64 cycles pass untaken.
// Assumes bjsm_pkg is compiled first and pclk runs free.
`timescale 1ns/1ps
`default_nettype none

module bjsm_seq_model
	import bjsm_pkg::*;
(
	// Clock and reset
	input  wire logic pclk,
	input  wire logic presetn,
	// Request handshake
	output logic      req_valid,
	input  wire logic req_ready,
	output bjsm_req_t req
);
	// ****************************************
	// Request driver
	// ****************************************
	initial begin
		req_valid = 1'b0;
		req       = '0;
	end

	// Stall cycles give slow as well as prompt offers
	task automatic send(input bjsm_req_t r, input int unsigned stall, output logic ok);
		int n;
		ok = 1'b0;
		repeat (stall + 1) @(posedge pclk);
		req       <= r;
		req_valid <= 1'b1;
		for (n = 0; n < 64 && !ok; n++) begin
			// Ready is judged between edges, where it has settled
			@(negedge pclk);
			ok = (req_ready === 1'b1);
			@(posedge pclk);
		end
		req_valid <= 1'b0;
		// Released operands must not keep looking valid
		req       <= ~r;
	endtask
endmodule

`default_nettype wire

// ### bit_jump_shift_mac_exec_tb.sv
// Self-checking bench for the execution slice with an APB master.
// Assumes bjsm_pkg, bjsm_exec and bjsm_seq_model are compiled first.
`timescale 1ns/1ps
`default_nettype none

module bit_jump_shift_mac_exec_tb;
	import bjsm_pkg::*;
	logic        pclk, presetn, psel, penable, pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [3:0]  pstrb;
	logic        pready, pslverr, req_valid, req_ready, done;
	bjsm_req_t   req;
	bjsm_res_t   res;
	int          miscompares, samples_checked;

	always #20 pclk = ~pclk;

	bjsm_exec bjsm_exec_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .req_valid(req_valid), .req_ready(req_ready),
		.req(req), .done(done), .res(res));
	bjsm_seq_model bjsm_seq_model_inst (.pclk(pclk), .presetn(presetn),
		.req_valid(req_valid), .req_ready(req_ready), .req(req));

	// ****************************************
	// Checking and closing
	// ****************************************
	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic test_done();
		if (miscompares == 0 && samples_checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	function automatic logic [15:0] lua_addr(input bjsm_req_t r);
		case (r.word[12:11])
			2'b00: return r.rn - r.nn;
			2'b01: return r.rn + r.nn;
			2'b10: return r.rn - 16'h0001;
			default: return r.rn + 16'h0001;
		endcase
	endfunction

	function automatic logic [55:0] mac_exp(input logic [55:0] a, input logic [23:0] x,
		input logic [23:0] y, input logic neg);
		longint p;
		p = longint'($signed(x)) * longint'($signed(y)) * 2;
		return neg ? a - 56'(p) : a + 56'(p);
	endfunction

	function automatic logic bit_of(input logic [23:0] v, input logic [4:0] b);
		return (b <= 5'h17) ? v[b] : 1'b0;
	endfunction

	// ****************************************
	// Bus and request tasks
	// ****************************************
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
		output logic [31:0] rd, output logic err);
		int n;
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		for (n = 0; n < 16; n++) begin
			@(posedge pclk);
			if (pready === 1'b1)
				break;
		end
		if (n >= 16) begin
			miscompares++;
			test_done();
		end
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	// Offers a request, then times the done pulse from the taking edge
	task automatic go(input bjsm_req_t r, input int unsigned n_exp);
		logic ok;
		int   n;
		bjsm_seq_model_inst.send(r, $urandom_range(2), ok);
		if (!ok) begin
			miscompares++;
			test_done();
		end
		for (n = 1; n < 40; n++) begin
			@(negedge pclk);
			if (done === 1'b1)
				break;
		end
		if (n >= 40) begin
			miscompares++;
			test_done();
		end
		chk(n, n_exp);
	endtask

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		bjsm_req_t   r;
		logic [31:0] rd;
		logic        err, tk;
		logic [55:0] a;
		logic [23:0] m;
		int          i;
		pclk = 1'b0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		pstrb = 4'hf;
		miscompares = 0;
		samples_checked = 0;
		void'($urandom(32'h1f16c9ec));
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, ADDR_CTRL, 32'h0, rd, err);
		chk(rd, 32'h1);
		apb(1'b0, 12'hffc, 32'h0, rd, err);
		chk({err, rd}, 33'h100000000);
		apb(1'b1, ADDR_CTRL, 32'h0, rd, err);
		#1;
		chk(req_ready, 1'b0);
		apb(1'b1, ADDR_CTRL, 32'h1, rd, err);
		for (i = 0; i < 40; i++) begin
			r = '0;
			r.word = 24'($urandom);
			r.extra = 4'($urandom_range(3));
			r.move_lim = 1'($urandom);
			r.acc_a = 56'({$urandom, $urandom});
			r.acc_b = 56'({$urandom, $urandom});
			r.src_mem = 24'($urandom);
			r.src_reg = 24'($urandom);
			// Scale and double-precision bits kept off here
			r.sr = 16'($urandom) & 16'h00ff;
			r.pc = 16'($urandom);
			r.ext = 24'($urandom);
			r.rn = 16'($urandom);
			r.nn = 16'($urandom);
			a = r.word[3] ? r.acc_b : r.acc_a;
			m = a[47:24];
			case (i % 5)
				0: begin
					r.op = OP_LSL;
					go(r, 2 + r.extra);
					chk(res.acc_val, {a[55:48], m[22:0], 1'b0, a[23:0]});
					chk({res.sr_val[6], res.sr_val[3:0]},
						{r.sr[6] | r.move_lim, m[22], m[22:0] == 23'h0, 1'b0, m[23]});
				end
				1: begin
					r.op = OP_LSR;
					go(r, 2 + r.extra);
					chk(res.acc_val, {a[55:48], 1'b0, m[23:1], a[23:0]});
					chk(res.sr_val[3:0], {1'b0, m[23:1] == 23'h0, 1'b0, m[0]});
				end
				2: begin
					r.op = OP_LUA;
					go(r, 4);
					chk(res.agu_val, lua_addr(r));
					chk({res.agu_we, res.agu_dst, res.acc_we}, {1'b1, r.word[3:0], 1'b0});
					chk(res.sr_val, r.sr);
				end
				3: begin
					r.op = OP_CALL_IO;
					tk = bit_of(r.src_mem, r.word[4:0]);
					go(r, 6 + r.extra);
					chk({res.io_addr, res.io_space}, {r.word[13:8], r.word[6]});
					chk(res.push, tk);
					chk(res.pc_next, tk ? r.ext[15:0] : 16'(r.pc + 16'h2));
					if (tk)
						chk({res.push_pc, res.push_sr}, {r.pc + 16'h2, r.sr});
				end
				default: begin
					r.op = OP_MAC;
					go(r, 2 + r.extra);
					chk(res.acc_val, mac_exp(a, r.src_mem, r.src_reg, r.word[2]));
					chk({res.acc_we, res.acc_sel}, {1'b1, r.word[3]});
				end
			endcase
		end
		// Register source from the arithmetic input group, bit 5
		r.op = OP_CALL_REG;
		r.extra = 4'h1;
		r.word = {10'h0, 6'h04, 3'h0, 5'h05};
		r.src_reg = 24'h000020;
		go(r, 7);
		chk({res.push, res.pc_next}, {1'b1, r.ext[15:0]});
		// Extension in use: limited to the positive maximum, accumulator kept
		r.extra = 4'h0;
		r.acc_a = 56'h01_000000_000000;
		r.sr = 16'h0000;
		r.word = {10'h0, SRC_ACC_A, 3'h0, 5'h17};
		go(r, 6);
		chk({res.push, res.acc_we, res.sr_val[CC_L]}, 3'b001);
		r.word = {10'h0, SRC_ACC_A, 3'h0, 5'h16};
		go(r, 6);
		chk({res.push, res.acc_we}, 2'b10);
		// Immediate form ignores the extra count
		r.op = OP_MAC_IMM;
		r.extra = 4'h3;
		go(r, 2);
		chk(res.acc_we, 1'b1);
		a = 56'($signed({{8{r.src_mem[23]}}, r.src_mem, 24'h000000}) >>> r.word[12:8]);
		chk(res.acc_val, 56'(r.word[2] ? r.acc_a - a : r.acc_a + a));
		// Double precision forced on through the control word
		apb(1'b1, ADDR_CTRL, 32'h3, rd, err);
		r.extra = 4'h0;
		r.op = OP_LSL;
		go(r, 2);
		chk({res.nop, res.acc_we, res.sr_val}, {2'b10, r.sr});
		r.op = OP_MPY;
		r.word = {17'h0, QQ_MPY_DP, 4'h0};
		go(r, 2);
		chk({res.dp_step, res.nop}, 2'b10);
		apb(1'b1, ADDR_CTRL, 32'h1, rd, err);
		test_done();
	end
endmodule

`default_nettype wire
